//--- dio_host_port.sv
// slave sequencer for the separate-strobe direct i/o host port
`timescale 1ns/1ps
module dio_host_port (
  input wire logic mclk, // 40 MHz clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic host_chip_select_n, // chip select
  input wire logic host_read_strobe_n, // read strobe
  input wire logic host_write_strobe_n, // write strobe
  input wire logic int_ack_strobe_n, // unused here, stays high
  input wire logic select_latch_strobe, // select latch, tie high to bypass
  input wire logic high_byte_enable_n, // high byte lane enable
  input wire logic reg_select_ext, // extended register select
  input wire logic [2:0] reg_select_bits, // register select
  input wire logic bus8_mode, // 8-bit bus mode strap
  input wire logic regs_ready, // host interface register ready
  input wire logic [7:0] host_data_high_i, // data high byte in
  input wire logic [7:0] host_data_low_i, // data low byte in
  output logic [7:0] host_data_high_o, // data high byte out
  output logic [7:0] host_data_low_o, // data low byte out
  output logic host_data_oe, // data output enable
  output logic buffer_direction, // low: toward device
  output logic buffer_enable_n, // buffer enable
  output logic host_ready_n_o, // ready level
  output logic host_ready_oe, // ready drive enable
  output logic wait_timeout // pulse: wait limit passed
);
  import dio_pkg::*;

  // two-flop synchronisers for the asynchronous inputs
  logic [9:0] s1_r, s2_r;
  logic [9:0] raw;
  assign raw = {host_chip_select_n, host_read_strobe_n, host_write_strobe_n,
                select_latch_strobe, high_byte_enable_n, reg_select_ext,
                reg_select_bits, int_ack_strobe_n};
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s1_r <= 10'h3FF;
      s2_r <= 10'h3FF;
    end else if (ce) begin
      s1_r <= raw;
      s2_r <= s1_r;
    end
  end
  logic cs_n, rd_n, wr_n, las, bhe_n, sx;
  logic [2:0] rs;
  assign cs_n = s2_r[9];
  assign rd_n = s2_r[8];
  assign wr_n = s2_r[7];
  assign las = s2_r[6];
  assign bhe_n = s2_r[5];
  assign sx = s2_r[4];
  assign rs = s2_r[3:1];

  // select latch: capture on falling edge, else transparent while high
  logic las_d_r, las_d_nxt, lat_valid_r, lat_valid_nxt;
  logic [5:0] lat_r, lat_nxt;
  logic [5:0] sel_live, sel_use;
  assign sel_live = {cs_n, bhe_n, sx, rs};
  always_comb begin
    las_d_nxt = las;
    lat_nxt = lat_r;
    lat_valid_nxt = lat_valid_r;
    if (las_d_r && !las) begin
      lat_nxt = sel_live;
      lat_valid_nxt = 1'b1;
    end else if (las) begin
      lat_valid_nxt = 1'b0;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      las_d_r <= 1'b1;
      lat_r <= 6'h3F;
      lat_valid_r <= 1'b0;
    end else if (ce) begin
      las_d_r <= las_d_nxt;
      lat_r <= lat_nxt;
      lat_valid_r <= lat_valid_nxt;
    end
  end
  // strapped high means selects are used directly
  assign sel_use = lat_valid_r ? lat_r : sel_live;

  function automatic logic [SEL_W-1:0] reg_index(input logic [5:0] s);
    reg_index = {s[SEL_EXT_BIT], s[2:0]};
  endfunction : reg_index

  // cycle start: later of chip select and a strobe low
  logic eff_cs_n, rd_act, wr_act, cyc_act;
  assign eff_cs_n = lat_valid_r ? lat_r[5] : cs_n;
  assign rd_act = !eff_cs_n && !rd_n;
  assign wr_act = !eff_cs_n && !wr_n;
  assign cyc_act = rd_act || wr_act;

  // main sequencer
  dio_state_t st_r, st_nxt;
  logic is_wr_r, is_wr_nxt, dir_r, dir_nxt, ben_r, ben_nxt;
  logic rdy_r, rdy_nxt, roe_r, roe_nxt, doe_r, doe_nxt, tmo_r, tmo_nxt;
  logic [WAIT_W-1:0] wcnt_r, wcnt_nxt;
  logic [SEL_W-1:0] idx_r, idx_nxt;
  logic bhe_r, bhe_nxt;
  logic [15:0] wd_r, wd_nxt;
  logic wr_lo, wr_hi;
  logic [15:0] rdata;

  always_comb begin
    st_nxt = st_r;
    is_wr_nxt = is_wr_r;
    dir_nxt = dir_r;
    ben_nxt = ben_r;
    rdy_nxt = rdy_r;
    roe_nxt = roe_r;
    doe_nxt = doe_r;
    tmo_nxt = 1'b0;
    wcnt_nxt = wcnt_r;
    idx_nxt = idx_r;
    bhe_nxt = bhe_r;
    wd_nxt = wd_r;
    wr_lo = 1'b0;
    wr_hi = 1'b0;
    case (st_r)
      ST_IDLE: begin
        if (cyc_act) begin
          is_wr_nxt = wr_act;
          idx_nxt = reg_index(sel_use);
          bhe_nxt = !sel_use[4] && !bus8_mode;
          if (wr_act) begin
            dir_nxt = 1'b0;
            st_nxt = ST_DIR;
          end else begin
            ben_nxt = 1'b0;
            st_nxt = ST_ENA;
          end
        end
      end
      ST_DIR: begin
        ben_nxt = 1'b0;
        st_nxt = ST_ENA;
      end
      ST_ENA: begin
        wcnt_nxt = '0;
        doe_nxt = !is_wr_r;
        st_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        // ready after data driven and register ready, or forced once wcnt_r reaches WAIT_MAX_CYC - 2
        if (regs_ready || wcnt_r == WAIT_W'(WAIT_MAX_CYC - 2)) begin
          tmo_nxt = !regs_ready;
          rdy_nxt = 1'b0;
          roe_nxt = 1'b1;
          st_nxt = ST_RDY;
        end else begin
          wcnt_nxt = wcnt_r + WAIT_W'(1);
        end
        wd_nxt = {host_data_high_i, host_data_low_i};
      end
      ST_RDY: begin
        if (is_wr_r) begin
          wd_nxt = {host_data_high_i, host_data_low_i};
        end
        if (!cyc_act) begin
          ben_nxt = 1'b1;
          rdy_nxt = 1'b1;
          doe_nxt = 1'b0;
          dir_nxt = 1'b1;
          if (is_wr_r) begin
            wr_lo = 1'b1;
            wr_hi = bhe_r;
          end
          st_nxt = ST_END;
        end
      end
      ST_END: begin
        roe_nxt = 1'b0;
        st_nxt = ST_IDLE;
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_r <= ST_IDLE;
      is_wr_r <= 1'b0;
      dir_r <= 1'b1;
      ben_r <= 1'b1;
      rdy_r <= 1'b1;
      roe_r <= 1'b0;
      doe_r <= 1'b0;
      tmo_r <= 1'b0;
      wcnt_r <= '0;
      idx_r <= '0;
      bhe_r <= 1'b0;
      wd_r <= 16'h0000;
    end else if (ce) begin
      st_r <= st_nxt;
      is_wr_r <= is_wr_nxt;
      dir_r <= dir_nxt;
      ben_r <= ben_nxt;
      rdy_r <= rdy_nxt;
      roe_r <= roe_nxt;
      doe_r <= doe_nxt;
      tmo_r <= tmo_nxt;
      wcnt_r <= wcnt_nxt;
      idx_r <= idx_nxt;
      bhe_r <= bhe_nxt;
      wd_r <= wd_nxt;
    end
  end

  // write uses data captured while enable was still low
  dio_regfile u_regs (
    .mclk(mclk),
    .ce(ce),
    .rst_b(rst_b),
    .addr(idx_r),
    .wr_lo(wr_lo),
    .wr_hi(wr_hi),
    .wdata(wd_r),
    .rdata(rdata)
  );

  // read data register; high byte zero in 8-bit mode
  logic [15:0] dout_r, dout_nxt;
  always_comb begin
    dout_nxt = rdata;
    if (bus8_mode) dout_nxt[15:8] = 8'h00;
  end
  always_ff @(posedge mclk) begin
    if (!rst_b) dout_r <= 16'h0000;
    else if (ce) dout_r <= dout_nxt;
  end

  assign host_data_high_o = dout_r[15:8];
  assign host_data_low_o = dout_r[7:0];
  assign host_data_oe = doe_r;
  assign buffer_direction = dir_r;
  assign buffer_enable_n = ben_r;
  assign host_ready_n_o = rdy_r;
  assign host_ready_oe = roe_r;
  assign wait_timeout = tmo_r;

  // checks
  sequence wr_start_s;
    st_r == ST_IDLE && wr_act && ce;
  endsequence
  sequence dir_then_en_s;
    !dir_r && ben_r ##1 !dir_r && !ben_r;
  endsequence
  wr_dir_first_a: assert property (
    @(posedge mclk) disable iff (!rst_b || !ce)
    wr_start_s |=> dir_then_en_s)
    else $error("write enable before direction");
  dir_low_a: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_start_s |=> !dir_r)
    else $error("direction not low after write start");
  rd_en_first_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(rdy_r) |-> !ben_r)
    else $error("ready before buffer enable");
  rdy_data_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(rdy_r) && !is_wr_r |-> doe_r)
    else $error("read ready before data driven");
  wait_bound_a: assert property (@(posedge mclk) disable iff (!rst_b)
    wcnt_r <= WAIT_W'(WAIT_MAX_CYC - 2))
    else $error("wait state too long");
  end_release_a: assert property (@(posedge mclk) disable iff (!rst_b)
    st_r == ST_RDY && !cyc_act && ce |=> ben_r && rdy_r)
    else $error("enable or ready not released");
  float_a: assert property (@(posedge mclk) disable iff (!rst_b)
    st_r == ST_END && ce |=> !roe_r)
    else $error("ready not floated");
  start_cond_a: assert property (@(posedge mclk) disable iff (!rst_b)
    st_r == ST_IDLE && st_nxt != ST_IDLE && ce |-> cyc_act)
    else $error("cycle started without select and strobe");
  hi_ignore_a: assert property (@(posedge mclk) disable iff (!rst_b)
    bus8_mode && wr_hi |-> 1'b0)
    else $error("high byte written in 8-bit mode");
  // release, drive and lane checks; a frozen clock enable holds them
  rd_release_a: assert property (@(posedge mclk) disable iff (!rst_b)
    st_r == ST_RDY && !is_wr_r && !cyc_act && ce |=> ben_r && !doe_r)
    else $error("read enable or data drive not released");
  wr_capture_a: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_lo |-> !ben_r && is_wr_r)
    else $error("write data stored after enable released");
  rdy_end_a: assert property (@(posedge mclk) disable iff (!rst_b)
    st_r == ST_END |-> rdy_r && roe_r)
    else $error("ready not driven high before float");
  tmo_state_a: assert property (@(posedge mclk) disable iff (!rst_b)
    tmo_r |-> st_r == ST_RDY && !rdy_r)
    else $error("timeout pulse outside forced ready");
  wait_rdy_a: assert property (@(posedge mclk) disable iff (!rst_b)
    st_r == ST_WAIT |-> rdy_r && !ben_r)
    else $error("ready or enable wrong during wait");
  idle_free_a: assert property (@(posedge mclk) disable iff (!rst_b)
    st_r == ST_IDLE |-> dir_r && ben_r && !doe_r)
    else $error("buffers not released in idle");
  idle_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    st_r == ST_IDLE && !cyc_act && ce |=> st_r == ST_IDLE)
    else $error("cycle left idle without select and strobe");
  rd_dir_a: assert property (@(posedge mclk) disable iff (!rst_b)
    st_r != ST_IDLE && !is_wr_r |-> dir_r)
    else $error("buffer direction turned on a read");
  rdy_oe_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !rdy_r |-> roe_r)
    else $error("ready low while not driven");
  hi_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
    bus8_mode && ce |=> host_data_high_o == 8'h00)
    else $error("high byte driven in 8-bit mode");
  lane_pair_a: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_hi |-> wr_lo)
    else $error("high lane written alone");
endmodule : dio_host_port

//--- dio_pkg.sv
// constants and types shared by the direct i/o host port
package dio_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int WAIT_MAX_NS = 4000;
  localparam int WAIT_MAX_CYC = WAIT_MAX_NS / CLK_PERIOD_NS;
  localparam int WAIT_W = 8;
  localparam int NUM_REGS = 16;
  localparam int SEL_W = 4;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam int SEL_EXT_BIT = 3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DIR = 3'b001,
    ST_ENA = 3'b010,
    ST_WAIT = 3'b011,
    ST_RDY = 3'b100,
    ST_END = 3'b101
  } dio_state_t;
endpackage : dio_pkg

//--- dio_regfile.sv
// sixteen-word register store with byte lane writes and registered read
`timescale 1ns/1ps
module dio_regfile (
  input wire logic mclk, // clock
  input wire logic ce, // clock enable
  input wire logic rst_b, // synchronous reset, active low
  input wire logic [3:0] addr, // word select
  input wire logic wr_lo, // write low byte
  input wire logic wr_hi, // write high byte
  input wire logic [15:0] wdata, // write data
  output logic [15:0] rdata // registered read data
);
  import dio_pkg::*;
  logic [15:0] mem_r [NUM_REGS];
  logic [15:0] rdata_nxt;

  // read mux
  always_comb begin
    rdata_nxt = mem_r[addr];
  end

  // store and read register
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_REGS; i++) mem_r[i] <= REG_RESET;
      rdata <= REG_RESET;
    end else if (ce) begin
      if (wr_lo) mem_r[addr][7:0] <= wdata[7:0];
      if (wr_hi) mem_r[addr][15:8] <= wdata[15:8];
      rdata <= rdata_nxt;
    end
  end
endmodule : dio_regfile

//--- host_bus_model.sv
// host bus model with separate read and write strobes
`timescale 1ns/1ps
module host_bus_model (
  input wire logic mclk, // clock
  input wire logic ready_n, // resolved ready line
  output logic cs_n, // chip select
  output logic rd_n, // read strobe
  output logic wr_n, // write strobe
  output logic iack_n, // interrupt acknowledge strobe
  output logic las, // select latch strobe
  output logic hbe_n, // high byte enable
  output logic [3:0] sel, // extended and plain selects
  output logic [15:0] dq // write data
);
  initial begin
    {cs_n, rd_n, wr_n, iack_n, las, hbe_n} = 6'h3F;
    sel = 4'h0;
    dq = 16'h0000;
  end
  // one access; in latch mode the selects are scrambled after the latch
  task automatic access(input logic wr, input logic [3:0] a,
      input logic [15:0] d, input logic he_n, input logic lat,
      output int cyc);
    @(posedge mclk);
    sel <= a;
    hbe_n <= he_n;
    dq <= d;
    // chip select goes with the selects so the latch takes it low
    cs_n <= 1'b0;
    repeat (2) @(posedge mclk);
    if (lat) begin
      las <= 1'b0;
      @(posedge mclk);
      sel <= ~a;
    end
    @(posedge mclk);
    rd_n <= wr;
    wr_n <= !wr;
    cyc = 0;
    do begin
      @(posedge mclk);
      cyc++;
    end while (ready_n !== 1'b0 && cyc < 400);
    // released one edge after ready, or after 400 cycles without it
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    las <= 1'b1;
    repeat (4) @(posedge mclk);
    dq <= ~dq;
    sel <= ~sel;
  endtask : access
endmodule : host_bus_model

//--- test_dio_host_port.sv
// self-checking bench for the direct i/o host port
`timescale 1ns/1ps
module test_dio_host_port;
  import dio_pkg::*;
  logic mclk, rst_b, bus8, rr, rdy, got;
  logic cs_n, rd_n, wr_n, iack_n, las, hbe_n;
  logic doe, dir, ben_n, rdy_o, rdy_oe, tmo;
  logic [3:0] sel;
  logic [7:0] dh, dl;
  logic [15:0] dq, img [16];
  logic [15:0] expq [$];
  logic [31:0] rnd;
  int fail_count, n_compared, n_tmo, cyc;
  // ready line has a pull-up when released
  assign rdy = rdy_oe ? rdy_o : 1'b1;
  host_bus_model i_host (.mclk(mclk), .ready_n(rdy), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .iack_n(iack_n), .las(las),
    .hbe_n(hbe_n), .sel(sel), .dq(dq));
  dio_host_port i_dut (.mclk(mclk), .rst_b(rst_b), .ce(1'b1),
    .host_chip_select_n(cs_n), .host_read_strobe_n(rd_n),
    .host_write_strobe_n(wr_n), .int_ack_strobe_n(iack_n),
    .select_latch_strobe(las), .high_byte_enable_n(hbe_n),
    .reg_select_ext(sel[3]), .reg_select_bits(sel[2:0]),
    .bus8_mode(bus8), .regs_ready(rr), .host_data_high_i(dq[15:8]),
    .host_data_low_i(dq[7:0]), .host_data_high_o(dh),
    .host_data_low_o(dl), .host_data_oe(doe), .buffer_direction(dir),
    .buffer_enable_n(ben_n), .host_ready_n_o(rdy_o),
    .host_ready_oe(rdy_oe), .wait_timeout(tmo));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    if (fail_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  // write access; the image follows lane and mode rules
  task automatic put(input logic [3:0] a, input logic [15:0] d,
      input logic he_n, input logic lat);
    i_host.access(1'b1, a, d, he_n, lat, cyc);
    if (!he_n && !bus8)
      img[a] = d;
    else
      img[a][7:0] = d[7:0];
  endtask : put
  // read access; the note is queued once the mode input has settled
  task automatic get(input logic [3:0] a, input logic lat);
    @(posedge mclk);
    expq.push_back(bus8 ? {8'h00, img[a][7:0]} : img[a]);
    i_host.access(1'b0, a, 16'h0000, 1'b0, lat, cyc);
  endtask : get
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // watcher: each data phase is judged when ready first goes low
  always @(posedge mclk) begin
    if (!cs_n && rdy === 1'b0 && !got) begin
      got <= 1'b1;
      check({15'h0, ben_n}, 16'h0000);
      if (!rd_n) begin
        check({14'h0, dir, doe}, 16'h0003);
        check({dh, dl}, expq.pop_front());
      end else
        check({15'h0, dir}, 16'h0000);
    end else if (cs_n)
      got <= 1'b0;
    if (tmo === 1'b1)
      n_tmo++;
  end
  initial begin
    rst_b = 1'b0;
    bus8 = 1'b0;
    rr = 1'b1;
    rnd = 32'h0000005A;
    foreach (img[i]) img[i] = REG_RESET;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 16; i++) get(i[3:0], 1'b0);
    // random word to every register, odd ones through the latch
    for (int i = 0; i < 16; i++) begin
      rnd = xs(rnd);
      put(i[3:0], rnd[15:0], 1'b0, i[0]);
    end
    for (int i = 0; i < 16; i++) get(i[3:0], i[1]);
    // high lane disabled, then 8-bit mode ignores the high byte
    put(4'h5, 16'hA55A, 1'b1, 1'b0);
    bus8 <= 1'b1;
    put(4'h6, 16'hC33C, 1'b0, 1'b0);
    get(4'h6, 1'b0);
    bus8 <= 1'b0;
    get(4'h5, 1'b0);
    get(4'h6, 1'b0);
    // register never ready: two back to back forced answers
    rr <= 1'b0;
    put(4'h7, 16'h1234, 1'b0, 1'b0);
    check({15'h0, cyc <= WAIT_MAX_CYC + 8}, 16'h0001);
    put(4'h7, 16'h4321, 1'b0, 1'b0);
    check({15'h0, cyc <= WAIT_MAX_CYC + 8}, 16'h0001);
    check(n_tmo[15:0], 16'h0002);
    // register becomes ready part way through the wait
    fork
      put(4'h8, 16'hBEEF, 1'b0, 1'b0);
      begin
        repeat (20) @(posedge mclk);
        rr <= 1'b1;
      end
    join
    check({15'h0, cyc > 10 && cyc < 40}, 16'h0001);
    check(n_tmo[15:0], 16'h0002);
    get(4'h8, 1'b0);
    // the float lands on the edge the access returns at
    @(posedge mclk);
    check({15'h0, rdy_oe}, 16'h0000);
    tally_and_finish();
  end
  // watchdog sized well past the longest sequence
  initial begin
    repeat (30000) @(posedge mclk);
    fail_count++;
    tally_and_finish();
  end
endmodule : test_dio_host_port
